// File: src/overlay_pkg.sv
package overlay_pkg;
  // ****************************************
  // Register map.
  // ****************************************
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_MAIN_OFS = 8'h44;
  localparam logic [7:0] ADDR_OVL_START = 8'h50;
  localparam logic [7:0] ADDR_OVL_OFS = 8'h54;
  localparam logic [7:0] ADDR_OVL_X = 8'h58;
  localparam logic [7:0] ADDR_OVL_Y = 8'h5C;
  localparam logic [7:0] ADDR_OVL_SIZE = 8'h60;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] POS_MASK = 32'h03FF_03FF;
  // ****************************************
  // Field layout.
  // ****************************************
  localparam int POS_W = 10;
  localparam int POS_LO_LSB = 0;
  localparam int POS_HI_LSB = 16;
  localparam int EN_BIT = 19;
  localparam int BPP_LSB = 0;
  localparam int BPP_W = 3;
  localparam int ROT_LSB = 6;
  localparam int ROT_W = 2;
  localparam logic [1:0] ROT_270 = 2'h3;
  localparam logic [2:0] BPP_MAX = 3'h4;
  localparam logic [2:0] DWORD_SHIFT = 3'h5;
  localparam int SIZE_W_LSB = 16;
  // ****************************************
  // Panel scan geometry, in rotated lines.
  // ****************************************
  localparam logic [9:0] LINE_LAST = 10'h13F;
  localparam int FADDR_W = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// File: src/overlay_window.sv
`timescale 1ns/1ps
// Function
// - Overlay shown rotated 270 degrees only when mode bits 7-6 equal 3.
// - X register: start bits 9-0, end 25-16.
// - Y register: start bits 9-0, end 25-16.
// - X gives vertical, Y horizontal window bounds.
// - Window size derived from truncated dword positions.
// - Overlay shown only while enable bit 19 set.
module overlay_window
  import overlay_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic overlay_sel,
  output logic [FADDR_W-1:0] fetch_addr,
  output logic [9:0] scan_line,
  output logic [9:0] scan_dword
);

  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] main_ofs;
    logic [31:0] ovl_start;
    logic [31:0] ovl_ofs;
    logic [31:0] ovl_x;
    logic [31:0] ovl_y;
    logic wr;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [9:0] line;
    logic [9:0] dw;
    logic [FADDR_W-1:0] main_addr;
    logic [FADDR_W-1:0] base;
    logic [FADDR_W-1:0] faddr;
    logic sel;
    logic [15:0] ovl_w;
    logic [10:0] ovl_h;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic [9:0] pos_start(input logic [31:0] r);
    pos_start = r[POS_LO_LSB +: POS_W];
  endfunction

  function automatic logic [9:0] pos_end(input logic [31:0] r);
    pos_end = r[POS_HI_LSB +: POS_W];
  endfunction

  logic [9:0] xs;
  logic [9:0] xe;
  logic [9:0] ys;
  logic [9:0] ye;
  logic [9:0] dw_last;
  logic en;
  logic rot270;
  logic in_win;
  logic [2:0] bpp;
  logic [2:0] shift;
  logic addr_ph;
  logic [FADDR_W-1:0] base_now;

  // ****************************************
  // Window geometry decode.
  // ****************************************
  always_comb begin
    xs = pos_start(s_r.ovl_x);
    xe = pos_end(s_r.ovl_x);
    ys = pos_start(s_r.ovl_y);
    ye = pos_end(s_r.ovl_y);
    en = s_r.mode[EN_BIT];
    rot270 = (s_r.mode[ROT_LSB +: ROT_W] == ROT_270);
    bpp = (s_r.mode[BPP_LSB +: BPP_W] > BPP_MAX) ? BPP_MAX : s_r.mode[BPP_LSB +: BPP_W];
    shift = DWORD_SHIFT - bpp;
    dw_last = (s_r.main_ofs[9:0] == 10'h000) ? 10'h000 : s_r.main_ofs[9:0] - 10'h001;
    // X bounds lines, Y bounds dwords.
    in_win = en && (s_r.line >= xs) && (s_r.line <= xe) && (s_r.dw >= ys) && (s_r.dw <= ye);
    addr_ph = hsel && hready && (htrans == HTRANS_NONSEQ);
    // Fresh base on the load cycle.
    base_now = ((s_r.line == xs) && (s_r.dw == 10'h000)) ? s_r.ovl_start[FADDR_W-1:0] : s_r.base;
  end

  // ****************************************
  // Bus slave and scan-out.
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    if (s_r.wr) begin
      unique case (s_r.addr)
        ADDR_MODE: begin
          s_nxt.mode = hwdata;
        end
        ADDR_MAIN_OFS: begin
          s_nxt.main_ofs = hwdata;
        end
        ADDR_OVL_START: begin
          s_nxt.ovl_start = hwdata;
        end
        ADDR_OVL_OFS: begin
          s_nxt.ovl_ofs = hwdata;
        end
        ADDR_OVL_X: begin
          s_nxt.ovl_x = hwdata & POS_MASK;
        end
        ADDR_OVL_Y: begin
          s_nxt.ovl_y = hwdata & POS_MASK;
        end
        default: begin
          s_nxt.mode = s_r.mode;
        end
      endcase
    end
    s_nxt.wr = addr_ph && hwrite;
    s_nxt.addr = haddr[7:0];
    s_nxt.rdata = REG_RESET;
    if (addr_ph && !hwrite && (haddr[31:8] == 24'h00_0000)) begin
      unique case (haddr[7:0])
        ADDR_MODE: begin
          s_nxt.rdata = s_r.mode;
        end
        ADDR_MAIN_OFS: begin
          s_nxt.rdata = s_r.main_ofs;
        end
        ADDR_OVL_START: begin
          s_nxt.rdata = s_r.ovl_start;
        end
        ADDR_OVL_OFS: begin
          s_nxt.rdata = s_r.ovl_ofs;
        end
        ADDR_OVL_X: begin
          s_nxt.rdata = s_r.ovl_x;
        end
        ADDR_OVL_Y: begin
          s_nxt.rdata = s_r.ovl_y;
        end
        ADDR_OVL_SIZE: begin
          s_nxt.rdata = {s_r.ovl_w, 5'h00, s_r.ovl_h};
        end
        default: begin
          s_nxt.rdata = REG_RESET;
        end
      endcase
    end
    if (s_r.wr && (s_r.addr[7:0] != ADDR_MODE) && (haddr[31:8] != 24'h00_0000)) begin
      s_nxt.rdata = REG_RESET;
    end
    s_nxt.ovl_w = 16'({6'h00, ye - ys + 10'h001} << shift);
    s_nxt.ovl_h = {1'b0, xe - xs} + 11'h001;
    if (s_r.dw >= dw_last) begin
      s_nxt.dw = 10'h000;
      s_nxt.line = (s_r.line >= LINE_LAST) ? 10'h000 : s_r.line + 10'h001;
    end else begin
      s_nxt.dw = s_r.dw + 10'h001;
    end
    s_nxt.main_addr = ((s_r.dw >= dw_last) && (s_r.line >= LINE_LAST)) ? '0 : s_r.main_addr + 16'h0001;
    if ((s_r.line == xs) && (s_r.dw == 10'h000)) begin
      s_nxt.base = s_r.ovl_start[FADDR_W-1:0];
    end else if (in_win && (s_r.dw == ye) && (s_r.line < xe)) begin
      s_nxt.base = rot270 ? s_r.base - s_r.ovl_ofs[FADDR_W-1:0] : s_r.base + s_r.ovl_ofs[FADDR_W-1:0];
    end
    s_nxt.sel = in_win;
    s_nxt.faddr = in_win ? base_now + {6'h00, s_r.dw - ys} : s_r.main_addr;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign overlay_sel = s_r.sel;
  assign fetch_addr = s_r.faddr;
  assign scan_line = s_r.line;
  assign scan_dword = s_r.dw;

  // ****************************************
  // Assertions.
  // ****************************************
  property p_en_gate;
    @(posedge hclk) disable iff (!hresetn) !en |=> !overlay_sel;
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("Overlay shown while disabled.");

  property p_sel_rows;
    @(posedge hclk) disable iff (!hresetn) overlay_sel |-> ($past(s_r.line) >= $past(xs)) && ($past(s_r.line) <= $past(xe));
  endproperty
  a_sel_rows: assert property (p_sel_rows) else $error("Overlay outside X bounds.");

  property p_sel_cols;
    @(posedge hclk) disable iff (!hresetn) overlay_sel |-> ($past(s_r.dw) >= $past(ys)) && ($past(s_r.dw) <= $past(ye));
  endproperty
  a_sel_cols: assert property (p_sel_cols) else $error("Overlay outside Y bounds.");

  property p_first_addr;
    @(posedge hclk) disable iff (!hresetn)
      (in_win && (s_r.line == xs) && (s_r.dw == ys) && (ys == 10'h000)) |=> fetch_addr == $past(s_r.ovl_start[FADDR_W-1:0]);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("Wrong first overlay address.");

  property p_step_270;
    @(posedge hclk) disable iff (!hresetn)
      (rot270 && in_win && (s_r.dw == ye) && (s_r.line < xe) && (s_r.dw != 10'h000)) |=> s_r.base == $past(s_r.base) - $past(s_r.ovl_ofs[FADDR_W-1:0]);
  endproperty
  a_step_270: assert property (p_step_270) else $error("Overlay line step wrong in 270 mode.");

  property p_x_fields;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.wr && (s_r.addr == ADDR_OVL_X)) |=> (xs == $past(hwdata[9:0])) && (xe == $past(hwdata[25:16]));
  endproperty
  a_x_fields: assert property (p_x_fields) else $error("X position fields misplaced.");

  property p_y_fields;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.wr && (s_r.addr == ADDR_OVL_Y)) |=> (ys == $past(hwdata[9:0])) && (ye == $past(hwdata[25:16]));
  endproperty
  a_y_fields: assert property (p_y_fields) else $error("Y position fields misplaced.");

  property p_width;
    @(posedge hclk) disable iff (!hresetn)
      ($stable(s_r.ovl_y) && $stable(s_r.mode) && (bpp == 3'h2)) |=> s_r.ovl_w == 16'({6'h00, $past(ye) - $past(ys) + 10'h001} << 3);
  endproperty
  a_width: assert property (p_width) else $error("Overlay width wrong at 4 bpp.");

  property p_ready;
    @(posedge hclk) disable iff (!hresetn) hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("Slave stalled or errored.");

  property p_height;
    @(posedge hclk) disable iff (!hresetn)
      $stable(s_r.ovl_x) |=> s_r.ovl_h == ({1'b0, $past(xe) - $past(xs)} + 11'h001);
  endproperty
  a_height: assert property (p_height) else $error("Overlay height wrong.");

  property p_main_addr;
    @(posedge hclk) disable iff (!hresetn)
      !in_win |=> fetch_addr == $past(s_r.main_addr);
  endproperty
  a_main_addr: assert property (p_main_addr) else $error("Main address not used outside window.");

  property p_sel_in_win;
    @(posedge hclk) disable iff (!hresetn)
      in_win |=> overlay_sel;
  endproperty
  a_sel_in_win: assert property (p_sel_in_win) else $error("Overlay missing inside window.");

  property p_line_wrap;
    @(posedge hclk) disable iff (!hresetn)
      ((s_r.dw >= dw_last) && (s_r.line >= LINE_LAST)) |=> scan_line == 10'h000;
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("Rotated scan did not wrap.");

  property p_dword_step;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.dw < dw_last) |=> scan_dword == ($past(s_r.dw) + 10'h001);
  endproperty
  a_dword_step: assert property (p_dword_step) else $error("Dword counter skipped.");

  property p_mode_write;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.wr && (s_r.addr == ADDR_MODE)) |=> en == $past(hwdata[EN_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("Enable bit not stored.");

  property p_rdata_idle;
    @(posedge hclk) disable iff (!hresetn)
      !addr_ph |=> hrdata == REG_RESET;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data left standing.");

  c_write: cover property (@(posedge hclk) disable iff (!hresetn) s_r.wr && (s_r.addr == ADDR_OVL_X));
  c_sel_rise: cover property (@(posedge hclk) disable iff (!hresetn) $rose(overlay_sel));
  c_line_step: cover property (@(posedge hclk) disable iff (!hresetn) rot270 && in_win && (s_r.dw == ye) && (s_r.line < xe));
  c_wrap: cover property (@(posedge hclk) disable iff (!hresetn) (s_r.line >= LINE_LAST) && (s_r.dw >= dw_last));

endmodule

// File: tb/scan_sink.sv
`timescale 1ns/1ps
// ****************************************
// Scan-out sink that counts overlay dwords.
// ****************************************
module scan_sink
  import overlay_pkg::*;
(
  input wire logic hclk,
  input wire logic clr,
  input wire logic overlay_sel,
  input wire logic [FADDR_W-1:0] fetch_addr,
  output int count
);
  always @(posedge hclk) begin
    if (clr) count <= 0;
    else if (overlay_sel === 1'b1) count <= count + 1;
  end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import overlay_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, clr = 1, chk_on = 0, win;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d, r;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, overlay_sel;
  logic [FADDR_W-1:0] fetch_addr;
  logic [9:0] scan_line, scan_dword, pl = 0, pd = 0;
  logic [7:0] regs [5] = '{ADDR_MAIN_OFS, ADDR_OVL_START, ADDR_OVL_OFS, ADDR_OVL_X, ADDR_OVL_Y};
  int errors = 0, compares = 0, cyc = 0, base = 0, cnt, en = 1, rot = 3;
  int xs = 2, xe = 5, ys = 1, ye = 3, st = 'h100, ofs = 'h10;
  always #25 hclk = ~hclk;
  overlay_window uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .overlay_sel(overlay_sel), .fetch_addr(fetch_addr),
    .scan_line(scan_line), .scan_dword(scan_dword));
  scan_sink sink (.hclk(hclk), .clr(clr), .overlay_sel(overlay_sel), .fetch_addr(fetch_addr), .count(cnt));
  // ****************************************
  // Checking and closing.
  // ****************************************
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // ****************************************
  // Scan model, one dword per clock.
  // ****************************************
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (chk_on) begin
      win = en != 0 && pl >= xs && pl <= xe && pd >= ys && pd <= ye;
      if (pl == xs && pd == 0) base = st;
      check("overlay_sel", {31'h0, overlay_sel}, {31'h0, win});
      if (win) check("fetch_addr", {16'h0, fetch_addr}, (base + pd - ys) & 'hFFFF);
      if (win && pd == ye && pl < xe) base = (rot == 3) ? base - ofs : base + ofs;
    end
    pl <= scan_line;
    pd <= scan_dword;
    if (cyc > 30000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(96));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (regs[i]) begin
      d = $urandom;
      xfer({24'h0, regs[i]}, 1'b1, d, r);
      xfer({24'h0, regs[i]}, 1'b0, 32'h0, r);
      check("readback", r, (i > 2) ? d & POS_MASK : d);
    end
    xfer(32'h0000_0070, 1'b1, $urandom, r);
    xfer(32'h0000_0070, 1'b0, 32'h0, r);
    check("unmapped", r, 32'h0);
    xfer({24'h0, ADDR_MODE}, 1'b1, 32'h0008_00C2, r);
    xfer({24'h0, ADDR_OVL_X}, 1'b1, 32'h00EF_0050, r);
    xfer({24'h0, ADDR_OVL_Y}, 1'b1, 32'h0016_0007, r);
    repeat (2) @(posedge hclk);
    xfer({24'h0, ADDR_OVL_SIZE}, 1'b1, $urandom, r);
    repeat (2) @(posedge hclk);
    xfer({24'h0, ADDR_OVL_SIZE}, 1'b0, 32'h0, r);
    check("size", r, 32'h0080_00A0);
    for (int p = 0; p < 3; p++) begin
      rot = (p == 1) ? 0 : 3;
      en = (p != 2);
      clr <= 1'b1;
      xfer({24'h0, ADDR_MODE}, 1'b1, (en << EN_BIT) | (rot << ROT_LSB) | 2, r);
      xfer({24'h0, ADDR_MAIN_OFS}, 1'b1, 32'h8, r);
      xfer({24'h0, ADDR_OVL_START}, 1'b1, st, r);
      xfer({24'h0, ADDR_OVL_OFS}, 1'b1, ofs, r);
      xfer({24'h0, ADDR_OVL_X}, 1'b1, (xe << 16) | xs, r);
      xfer({24'h0, ADDR_OVL_Y}, 1'b1, (ye << 16) | ys, r);
      repeat (2) @(posedge hclk);
      while (!(scan_line == 10'h0 && scan_dword == 10'h0)) @(posedge hclk);
      chk_on <= 1'b1;
      clr <= 1'b0;
      repeat (2560) @(posedge hclk);
      chk_on <= 1'b0;
      check("overlay_count", cnt, en ? 12 : 0);
    end
    test_done();
  end
endmodule
